// *** src/pgwr_pkg.sv ***
// package for the planar graphics write/read datapath
// assumes one 100 MHz clock and a host that issues byte or word cycles
package pgwr_pkg;
	// controller index values
	localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
	localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
	localparam logic [3:0] IDX_CMP_COLOUR = 4'h2;
	localparam logic [3:0] IDX_ROT_FUNC = 4'h3;
	localparam logic [3:0] IDX_READ_PLANE = 4'h4;
	localparam logic [3:0] IDX_MODE_CTRL = 4'h5;
	localparam logic [3:0] IDX_MEM_MAP = 4'h6;
	localparam logic [3:0] IDX_CMP_ENABLE = 4'h7;
	localparam logic [3:0] IDX_WRITE_MASK = 4'h8;
	// display-timing index of the latch readback
	localparam logic [7:0] IDX_LATCH_READBACK = 8'h22;
	// field positions
	localparam int ROT_CNT_LSB = 0;
	localparam int FUNC_LSB = 3;
	localparam int WMODE_LSB = 0;
	localparam int RMODE_BIT = 3;
	localparam int ODDEVEN_BIT = 4;
	// writable bit masks; other bits are reserved and read zero
	localparam logic [7:0] MASK_PLANE4 = 8'h0f;
	localparam logic [7:0] MASK_ROT_FUNC = 8'h1f;
	localparam logic [7:0] MASK_READ_PLANE = 8'h03;
	localparam logic [7:0] MASK_MODE_CTRL = 8'h7b;
	localparam logic [7:0] MASK_MEM_MAP = 8'h0f;
	localparam logic [7:0] MASK_FULL = 8'hff;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_WRITE_MASK = 8'hff;
	// write modes and logical functions
	localparam logic [1:0] WM_FILL = 2'h0;
	localparam logic [1:0] WM_LATCH = 2'h1;
	localparam logic [1:0] WM_COLOUR = 2'h2;
	localparam logic [1:0] WM_MASKED = 2'h3;
	localparam logic [1:0] FN_PASS = 2'h0;
	localparam logic [1:0] FN_AND = 2'h1;
	localparam logic [1:0] FN_OR = 2'h2;
	localparam logic [1:0] FN_XOR = 2'h3;
endpackage : pgwr_pkg

// *** src/pgwr_datapath.sv ***
// planar display-memory datapath: controller registers, write path, reads
// assumes the host strobes are synchronous to i_clk, one cycle each, and
// that memory read data is valid in the cycle of i_mem_rd
//
// Functional notes
// RULE1 - write-only index register selects data register
// RULE2 - one data port reaches indexed registers
// RULE3 - mode 0 enabled planes take fill bit
// RULE4 - fill enable picks host data or constant
// RULE5 - fill enable only acts in mode 0
// RULE6 - compare read returns per-pixel colour match
// RULE7 - host data rotated right, modes 0 and 3
// RULE8 - function: pass, and, or, xor latches
// RULE9 - plane-select read returns chosen plane byte
// RULE10 - odd/even drops bit0, quad drops both
// RULE11 - four write modes, per byte lane
// RULE12 - unfilled planes get rotated host data
// RULE13 - mode 1 writes latches, ignores host data
// RULE14 - every memory read reloads all latches
// RULE15 - mode 2 host data is pixel colour
// RULE16 - mode 2 ignores fill, keeps function
// RULE17 - mode 3 rotated data and mask
// RULE18 - mode 3 mask picks fill or latch
// RULE19 - index 22h reads selected latch, read-only
// RULE20 - order: rotate, fill, function, mask
// RULE21 - read mode bit picks compare reads
// RULE22 - compare enable excludes planes at zero
// RULE23 - bit mask zero takes latch, all planes
// RULE24 - bit mask governs all written data
// RULE25 - reserved bits read zero
module pgwr_datapath
	import pgwr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_idx_wr,
	input wire logic [7:0] i_idx_wdata,
	input wire logic i_data_wr,
	input wire logic i_data_rd,
	input wire logic [7:0] i_data_wdata,
	output logic [7:0] o_data_rdata,
	input wire logic i_crt_rd,
	input wire logic [7:0] i_crt_index,
	output logic [7:0] o_crt_rdata,
	input wire logic i_quad_mode,
	input wire logic i_mem_wr,
	input wire logic i_mem_rd,
	input wire logic [1:0] i_mem_be,
	input wire logic [15:0] i_mem_wdata,
	input wire logic [63:0] i_mem_rdata,
	output logic [15:0] o_mem_rdata,
	output logic [63:0] o_plane_wdata,
	output logic [1:0] o_plane_we
);

	////////////////////////////////////////////////////////////////////
	// registers
	logic [3:0] index_q;
	logic [7:0] fill_value_q;
	logic [7:0] fill_enable_q;
	logic [7:0] cmp_colour_q;
	logic [7:0] rot_func_q;
	logic [7:0] read_plane_q;
	logic [7:0] mode_ctrl_q;
	logic [7:0] mem_map_q;
	logic [7:0] cmp_enable_q;
	logic [7:0] write_mask_q;
	logic [31:0] latch_q;
	logic [7:0] data_rd_d;

	// index pointer, writes only, upper bits dropped
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			index_q <= 4'h0;
		end else if (i_idx_wr) begin
			index_q <= i_idx_wdata[3:0]; // RULE1
		end
	end

	// index port checks
	a_index_low: assert property ( // RULE1
		@(posedge i_clk) disable iff (i_rst)
		i_idx_wr |=> index_q == $past(i_idx_wdata[3:0]))
		else $error("index not taken");
	a_index_hold: assert property ( // RULE1
		@(posedge i_clk) disable iff (i_rst)
		!i_idx_wr |=> $stable(index_q))
		else $error("index moved without a write");

	// indexed register writes, reserved bits forced to zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fill_value_q <= RST_ZERO;
			fill_enable_q <= RST_ZERO;
			cmp_colour_q <= RST_ZERO;
			rot_func_q <= RST_ZERO;
			read_plane_q <= RST_ZERO;
			mode_ctrl_q <= RST_ZERO;
			mem_map_q <= RST_ZERO;
			cmp_enable_q <= RST_ZERO;
			write_mask_q <= RST_WRITE_MASK;
		end else if (i_data_wr) begin
			case (index_q) // RULE2
			IDX_FILL_VALUE: fill_value_q <= i_data_wdata & MASK_PLANE4; // RULE25
			IDX_FILL_ENABLE: fill_enable_q <= i_data_wdata & MASK_PLANE4;
			IDX_CMP_COLOUR: cmp_colour_q <= i_data_wdata & MASK_PLANE4;
			IDX_ROT_FUNC: rot_func_q <= i_data_wdata & MASK_ROT_FUNC;
			IDX_READ_PLANE: read_plane_q <= i_data_wdata & MASK_READ_PLANE;
			IDX_MODE_CTRL: mode_ctrl_q <= i_data_wdata & MASK_MODE_CTRL;
			IDX_MEM_MAP: mem_map_q <= i_data_wdata & MASK_MEM_MAP;
			IDX_CMP_ENABLE: cmp_enable_q <= i_data_wdata & MASK_PLANE4;
			IDX_WRITE_MASK: write_mask_q <= i_data_wdata & MASK_FULL;
			default: ;
			endcase
		end
	end

	// data port read mux
	always_comb begin
		case (index_q)
		IDX_FILL_VALUE: data_rd_d = fill_value_q;
		IDX_FILL_ENABLE: data_rd_d = fill_enable_q;
		IDX_CMP_COLOUR: data_rd_d = cmp_colour_q;
		IDX_ROT_FUNC: data_rd_d = rot_func_q;
		IDX_READ_PLANE: data_rd_d = read_plane_q;
		IDX_MODE_CTRL: data_rd_d = mode_ctrl_q;
		IDX_MEM_MAP: data_rd_d = mem_map_q;
		IDX_CMP_ENABLE: data_rd_d = cmp_enable_q;
		IDX_WRITE_MASK: data_rd_d = write_mask_q;
		default: data_rd_d = 8'h00; // RULE25
		endcase
	end

	// data port read register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_data_rdata <= 8'h00;
		end else if (i_data_rd) begin
			o_data_rdata <= data_rd_d;
		end
	end

	// register port checks
	a_reserved_zero: assert property ( // RULE25
		@(posedge i_clk) disable iff (i_rst)
		fill_value_q[7:4] == 4'h0 && rot_func_q[7:5] == 3'h0)
		else $error("reserved bits set");
	a_mode_reserved: assert property ( // RULE25
		@(posedge i_clk) disable iff (i_rst)
		read_plane_q[7:2] == 6'h0 && mode_ctrl_q[7] == 1'b0
		&& mode_ctrl_q[2] == 1'b0 && cmp_enable_q[7:4] == 4'h0)
		else $error("reserved mode bits set");
	a_data_rd_zero: assert property ( // RULE25
		@(posedge i_clk) disable iff (i_rst)
		i_data_rd && index_q > IDX_WRITE_MASK |=> o_data_rdata == 8'h00)
		else $error("unused index read not zero");
	a_rdata_hold: assert property ( // RULE2
		@(posedge i_clk) disable iff (i_rst)
		!i_data_rd |=> $stable(o_data_rdata))
		else $error("data port read value moved");

	////////////////////////////////////////////////////////////////////
	// field decode
	logic [2:0] rot_cnt;
	logic [1:0] func_sel;
	logic [1:0] wmode;
	logic rmode;
	logic odd_even;
	logic [1:0] eff_plane;
	assign rot_cnt = rot_func_q[ROT_CNT_LSB +: 3];
	assign func_sel = rot_func_q[FUNC_LSB +: 2];
	assign wmode = mode_ctrl_q[WMODE_LSB +: 2];
	assign rmode = mode_ctrl_q[RMODE_BIT];
	assign odd_even = mode_ctrl_q[ODDEVEN_BIT];

	// effective read plane, low bit or both dropped by addressing mode
	always_comb begin
		if (i_quad_mode) begin
			eff_plane = 2'h0; // RULE10
		end else if (odd_even) begin
			eff_plane = {read_plane_q[1], 1'b0}; // RULE10
		end else begin
			eff_plane = read_plane_q[1:0]; // RULE9
		end
	end

	// latch readback on the display-timing port, writes never decoded
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_crt_rdata <= 8'h00;
		end else if (i_crt_rd) begin
			if (i_crt_index == IDX_LATCH_READBACK) begin
				o_crt_rdata <= latch_q[read_plane_q[1:0]*8 +: 8]; // RULE19
			end else begin
				o_crt_rdata <= 8'h00;
			end
		end
	end

	// latch readback checks, field taken as written
	a_crt_readback: assert property ( // RULE19
		@(posedge i_clk) disable iff (i_rst)
		i_crt_rd && i_crt_index == IDX_LATCH_READBACK && !i_mem_rd
		|=> o_crt_rdata == latch_q[$past(read_plane_q[1:0])*8 +: 8])
		else $error("latch readback wrong");
	a_crt_other: assert property ( // RULE19
		@(posedge i_clk) disable iff (i_rst)
		i_crt_rd && i_crt_index != IDX_LATCH_READBACK |=> o_crt_rdata == 8'h00)
		else $error("other display index not zero");

	////////////////////////////////////////////////////////////////////
	// per byte lane: read result and write data
	logic [15:0] rd_lane;
	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : g_lane
			logic [31:0] mem_b;
			logic [7:0] host_b;
			logic [7:0] rot_b;
			logic [7:0] match_b;
			logic [7:0] pix_mask;
			logic [31:0] src_b;
			logic [31:0] fn_b;
			logic [31:0] out_b;
			logic [31:0] wr_q;
			assign mem_b = {i_mem_rdata[48 + l*8 +: 8],
				i_mem_rdata[32 + l*8 +: 8],
				i_mem_rdata[16 + l*8 +: 8],
				i_mem_rdata[l*8 +: 8]};
			assign host_b = i_mem_wdata[l*8 +: 8];
			// rotate right by count
			assign rot_b = 8'((16'({host_b, host_b}) >> rot_cnt)); // RULE7

			// colour compare per pixel
			always_comb begin
				for (int p = 0; p < 8; p++) begin
					match_b[p] = 1'b1;
					for (int k = 0; k < 4; k++) begin
						if (cmp_enable_q[k] &&
							(mem_b[k*8 + p] != cmp_colour_q[k])) begin
							match_b[p] = 1'b0; // RULE6 RULE22
						end
					end
				end
			end
			assign rd_lane[l*8 +: 8] = rmode ? match_b : // RULE21
				mem_b[eff_plane*8 +: 8]; // RULE9

			// source select, function, mask merge per plane
			always_comb begin
				pix_mask = write_mask_q; // RULE23
				src_b = 32'h0;
				fn_b = 32'h0;
				out_b = 32'h0;
				if (wmode == WM_MASKED) begin
					pix_mask = rot_b & write_mask_q; // RULE17
				end
				for (int k = 0; k < 4; k++) begin
					case (wmode) // RULE11 RULE20
					WM_FILL: begin
						if (fill_enable_q[k]) begin // RULE4 RULE5
							src_b[k*8 +: 8] = {8{fill_value_q[k]}}; // RULE3
						end else begin
							src_b[k*8 +: 8] = rot_b; // RULE12
						end
					end
					WM_COLOUR: src_b[k*8 +: 8] = {8{host_b[k]}}; // RULE15 RULE16
					WM_MASKED: src_b[k*8 +: 8] = {8{fill_value_q[k]}}; // RULE18
					default: src_b[k*8 +: 8] = latch_q[k*8 +: 8]; // RULE13
					endcase
					case (func_sel) // RULE8
					FN_AND: fn_b[k*8 +: 8] = src_b[k*8 +: 8] & latch_q[k*8 +: 8];
					FN_OR: fn_b[k*8 +: 8] = src_b[k*8 +: 8] | latch_q[k*8 +: 8];
					FN_XOR: fn_b[k*8 +: 8] = src_b[k*8 +: 8] ^ latch_q[k*8 +: 8];
					default: fn_b[k*8 +: 8] = src_b[k*8 +: 8];
					endcase
					// mode 1 and mode 3 take no function
					if (wmode == WM_LATCH || wmode == WM_MASKED) begin
						fn_b[k*8 +: 8] = src_b[k*8 +: 8];
					end
					out_b[k*8 +: 8] = (fn_b[k*8 +: 8] & pix_mask) |
						(latch_q[k*8 +: 8] & ~pix_mask); // RULE24
					if (wmode == WM_LATCH) begin
						out_b[k*8 +: 8] = latch_q[k*8 +: 8]; // RULE13
					end
				end
			end

			// write data register per lane, one process per flop set
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					wr_q <= 32'h0;
				end else if (i_mem_wr && i_mem_be[l]) begin
					wr_q <= out_b;
				end
			end
			// spread the lane register over the plane-major output
			for (genvar pk = 0; pk < 4; pk++) begin : g_plane
				assign o_plane_wdata[pk*16 + l*8 +: 8] = wr_q[pk*8 +: 8];
			end
		end
	endgenerate

	// write enables, one cycle after the host write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_plane_we <= 2'h0;
		end else begin
			o_plane_we <= i_mem_wr ? i_mem_be : 2'h0; // RULE11
		end
	end

	// write path checks
	a_plane_we: assert property ( // RULE11
		@(posedge i_clk) disable iff (i_rst)
		i_mem_wr |=> o_plane_we == $past(i_mem_be))
		else $error("write enable wrong");
	a_we_idle: assert property ( // RULE11
		@(posedge i_clk) disable iff (i_rst)
		!i_mem_wr |=> o_plane_we == 2'h0)
		else $error("write enable without a write");
	a_lane_hold: assert property ( // RULE11
		@(posedge i_clk) disable iff (i_rst)
		i_mem_wr && !i_mem_be[1] |=> $stable(o_plane_wdata[15:8]))
		else $error("disabled lane changed");
	a_fill_mode0: assert property ( // RULE3
		@(posedge i_clk) disable iff (i_rst)
		i_mem_wr && i_mem_be[0] && wmode == WM_FILL && fill_enable_q[0]
		&& func_sel == FN_PASS
		|=> (o_plane_wdata[7:0] & $past(write_mask_q)) ==
		({8{$past(fill_value_q[0])}} & $past(write_mask_q)))
		else $error("fill value not written");
	a_mode1_latch: assert property ( // RULE13
		@(posedge i_clk) disable iff (i_rst)
		i_mem_wr && i_mem_be[0] && wmode == WM_LATCH && !i_mem_rd
		|=> o_plane_wdata[7:0] == latch_q[7:0])
		else $error("mode 1 did not write latches");
	a_mask_latch: assert property ( // RULE23
		@(posedge i_clk) disable iff (i_rst)
		i_mem_wr && i_mem_be[0] && !i_mem_rd
		|=> (o_plane_wdata[7:0] & ~$past(write_mask_q)) ==
		(latch_q[7:0] & ~$past(write_mask_q)))
		else $error("mask did not protect");

	// latches reload on every memory read, from lane 0 when its enable is set, else from lane 1
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			latch_q <= 32'h0;
		end else if (i_mem_rd) begin
			for (int k = 0; k < 4; k++) begin
				latch_q[k*8 +: 8] <= i_mem_be[0] ? i_mem_rdata[k*16 +: 8] :
					i_mem_rdata[k*16 + 8 +: 8]; // RULE14
			end
		end
	end

	// latch reload check
	a_latch_reload: assert property ( // RULE14
		@(posedge i_clk) disable iff (i_rst)
		i_mem_rd && i_mem_be[0] |=> latch_q[7:0] == $past(i_mem_rdata[7:0]))
		else $error("latch not reloaded");

	// memory read data register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_mem_rdata <= 16'h0;
		end else if (i_mem_rd) begin
			o_mem_rdata <= rd_lane;
		end
	end

	// read path checks
	a_mem_rd_plane: assert property ( // RULE9
		@(posedge i_clk) disable iff (i_rst)
		i_mem_rd && !rmode && !i_quad_mode && !odd_even
		|=> o_mem_rdata[7:0] == $past(i_mem_rdata[read_plane_q[1:0]*16 +: 8]))
		else $error("plane read wrong");
	a_quad_plane0: assert property ( // RULE10
		@(posedge i_clk) disable iff (i_rst)
		i_mem_rd && !rmode && i_quad_mode |=> o_mem_rdata[7:0] == $past(i_mem_rdata[7:0]))
		else $error("quad read not plane 0");
	a_mem_rdata_hold: assert property ( // RULE21
		@(posedge i_clk) disable iff (i_rst)
		!i_mem_rd |=> $stable(o_mem_rdata))
		else $error("memory read value moved");

endmodule : pgwr_datapath

// *** verification/pgwr_plane_mem.sv ***
// four-plane display memory model facing the datapath
// assumes plane k lane l at bits k*16+l*8 of both 64-bit buses
module pgwr_plane_mem #(
	parameter logic [63:0] INIT = 64'h0
) (
	input wire logic i_clk,
	input wire logic [63:0] i_wdata,
	input wire logic [1:0] i_we,
	output logic [63:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_rdata = INIT;
	// each enabled lane is written in all four planes
	always @(posedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			for (int l = 0; l < 2; l++) begin
				if (i_we[l]) begin
					o_rdata[k*16+l*8+:8] <= i_wdata[k*16+l*8+:8];
				end
			end
		end
	end
endmodule : pgwr_plane_mem

// *** verification/tb.sv ***
// self-checking bench for the planar datapath
// assumes the plane store model answers reads in the same cycle
module tb;
	import pgwr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] INIT = 64'h7e0f_81f0_663c_99a5;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_idx_wr = 1'b0;
	logic i_data_wr = 1'b0;
	logic i_data_rd = 1'b0;
	logic i_crt_rd = 1'b0;
	logic i_quad_mode = 1'b0;
	logic i_mem_wr = 1'b0;
	logic i_mem_rd = 1'b0;
	logic [7:0] i_idx_wdata = 8'h00;
	logic [7:0] i_data_wdata = 8'h00;
	logic [7:0] i_crt_index = 8'h00;
	logic [1:0] i_mem_be = 2'h0;
	logic [15:0] i_mem_wdata = 16'h0000;
	logic [7:0] o_data_rdata, o_crt_rdata, d, ex;
	logic [15:0] o_mem_rdata;
	logic [63:0] o_plane_wdata, mem_q;
	logic [1:0] o_plane_we, fn;
	logic [7:0] lat [4];
	logic [3:0] fv, fe;
	logic [2:0] rot;
	logic [7:0] bm;
	logic [7:0] rmask [10];
	int err_total = 0;
	int compares = 0;

	always #5 i_clk = ~i_clk;

	pgwr_datapath u_pgwr_datapath (.i_clk(i_clk), .i_rst(i_rst),
		.i_idx_wr(i_idx_wr), .i_idx_wdata(i_idx_wdata),
		.i_data_wr(i_data_wr), .i_data_rd(i_data_rd),
		.i_data_wdata(i_data_wdata), .o_data_rdata(o_data_rdata),
		.i_crt_rd(i_crt_rd), .i_crt_index(i_crt_index),
		.o_crt_rdata(o_crt_rdata), .i_quad_mode(i_quad_mode),
		.i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd), .i_mem_be(i_mem_be),
		.i_mem_wdata(i_mem_wdata), .i_mem_rdata(mem_q),
		.o_mem_rdata(o_mem_rdata), .o_plane_wdata(o_plane_wdata),
		.o_plane_we(o_plane_we));
	pgwr_plane_mem #(.INIT(INIT)) u_pgwr_plane_mem (.i_clk(i_clk),
		.i_wdata(o_plane_wdata), .i_we(o_plane_we), .o_rdata(mem_q));

	////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task close_out;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	task reg_wr(input logic [7:0] idx, input logic [7:0] val);
		@(negedge i_clk) {i_idx_wr, i_idx_wdata} = {1'b1, idx};
		@(negedge i_clk) {i_idx_wr, i_data_wr, i_data_wdata} = {2'b01, val};
		@(negedge i_clk) i_data_wr = 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [7:0] idx, input logic [7:0] exp);
		@(negedge i_clk) {i_idx_wr, i_idx_wdata} = {1'b1, idx};
		@(negedge i_clk) {i_idx_wr, i_data_rd} = 2'b01;
		@(negedge i_clk) i_data_rd = 1'b0;
		chk(o_data_rdata, exp);
	endtask : reg_rd
	task crt_rd(input logic [7:0] idx, input logic [7:0] exp);
		@(negedge i_clk) {i_crt_rd, i_crt_index} = {1'b1, idx};
		@(negedge i_clk) i_crt_rd = 1'b0;
		chk(o_crt_rdata, exp);
	endtask : crt_rd
	// word read, so the latches reload from lane 0
	task mem_rd;
		@(negedge i_clk) {i_mem_rd, i_mem_be} = 3'b111;
		@(negedge i_clk) i_mem_rd = 1'b0;
	endtask : mem_rd
	task mem_wr(input logic [1:0] be, input logic [15:0] val);
		@(negedge i_clk) {i_mem_wr, i_mem_be, i_mem_wdata} = {1'b1, be, val};
		@(negedge i_clk) i_mem_wr = 1'b0;
	endtask : mem_wr
	// colour match of lane l against reference 5h over planes 0, 1 and 3
	function automatic logic [7:0] cmpv(input int l);
		logic [7:0] r;
		logic [3:0] cc;
		r = 8'hff;
		cc = 4'h5;
		for (int i = 0; i < 8; i++)
			for (int k = 0; k < 4; k++)
				if (k != 2 && INIT[k*16+l*8+i] != cc[k]) r[i] = 1'b0;
		return r;
	endfunction : cmpv
	// expected plane byte for one write
	function automatic logic [7:0] ref_wr(input logic [1:0] m,
		input logic [7:0] dv, input int k);
		logic [7:0] r, v, msk;
		r = 8'({dv, dv} >> rot);
		case (m)
			2'h0: v = fe[k] ? {8{fv[k]}} : r;
			2'h1: v = lat[k];
			2'h2: v = {8{dv[k]}};
			default: v = {8{fv[k]}};
		endcase
		if (m == 2'h0 || m == 2'h2)
			case (fn)
				FN_AND: v = v & lat[k];
				FN_OR: v = v | lat[k];
				FN_XOR: v = v ^ lat[k];
				default: v = v;
			endcase
		msk = (m == 2'h3) ? (r & bm) : ((m == 2'h1) ? 8'hff : bm);
		return (v & msk) | (lat[k] & ~msk);
	endfunction : ref_wr

	////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#100000;
		err_total++;
		close_out();
	end
	// main sequence
	initial begin
		rmask = '{MASK_PLANE4, MASK_PLANE4, MASK_PLANE4, MASK_ROT_FUNC,
			MASK_READ_PLANE, MASK_MODE_CTRL, MASK_MEM_MAP, MASK_PLANE4,
			MASK_FULL, 8'h00};
		repeat (16) @(negedge i_clk);
		i_rst = 1'b0;
		reg_rd({4'h0, IDX_WRITE_MASK}, RST_WRITE_MASK);
		reg_rd({4'h0, IDX_FILL_VALUE}, RST_ZERO);
		for (int i = 0; i < 10; i++) begin
			reg_wr({4'hf, 4'(i)}, 8'hff);
			reg_rd({4'ha, 4'(i)}, rmask[i]);
		end
		reg_wr(8'h05, 8'h00);
		reg_wr(8'h04, 8'h02);
		mem_rd();
		chk(o_mem_rdata[7:0], INIT[32+:8]);
		chk(o_mem_rdata[15:8], INIT[40+:8]);
		crt_rd(IDX_LATCH_READBACK, INIT[32+:8]);
		crt_rd(8'h21, 8'h00);
		i_quad_mode = 1'b1;
		mem_rd();
		chk(o_mem_rdata[7:0], INIT[7:0]);
		i_quad_mode = 1'b0;
		reg_wr(8'h05, 8'h10);
		reg_wr(8'h04, 8'h03);
		mem_rd();
		chk(o_mem_rdata[7:0], INIT[32+:8]);
		reg_wr(8'h02, 8'h05);
		reg_wr(8'h07, 8'h0b);
		reg_wr(8'h05, 8'h08);
		mem_rd();
		chk(o_mem_rdata[7:0], cmpv(0));
		chk(o_mem_rdata[15:8], cmpv(1));
		{fv, fe, rot, bm} = {4'h5, 4'h3, 3'h3, 8'hf0};
		reg_wr(8'h00, {4'h0, fv});
		reg_wr(8'h01, {4'h0, fe});
		reg_wr(8'h08, bm);
		for (int k = 0; k < 4; k++) lat[k] = INIT[k*16+:8];
		for (int i = 0; i < 8; i++) begin
			fn = 2'(i >> 1);
			d = 8'h96 ^ 8'(i * 37);
			reg_wr(8'h03, {3'h0, fn, rot});
			reg_wr(8'h05, {6'h0, 2'(i)});
			mem_rd();
			mem_wr(2'b01, {8'h00, d});
			chk({6'h0, o_plane_we}, 8'h01);
			for (int k = 0; k < 4; k++) begin
				ex = ref_wr(2'(i), d, k);
				chk(o_plane_wdata[k*16+:8], ex);
				lat[k] = ex;
			end
		end
		// one word write in mode 0, both lanes use the same latches
		reg_wr(8'h05, 8'h00);
		mem_rd();
		mem_wr(2'b11, 16'h5ac3);
		chk({6'h0, o_plane_we}, 8'h03);
		for (int k = 0; k < 4; k++) begin
			chk(o_plane_wdata[k*16+:8], ref_wr(2'h0, 8'hc3, k));
			chk(o_plane_wdata[k*16+8+:8], ref_wr(2'h0, 8'h5a, k));
		end
		close_out();
	end
endmodule : tb
